// file: bench/i2cms_bus_model.sv
// Two-wire bus model: pull-ups, this master and a second master
`timescale 1ns/10ps
module i2cms_bus_model (
    input  wire logic scl_oe,
    input  wire logic scl_o,
    input  wire logic sda_oe,
    input  wire logic sda_o,
    input  wire logic other_scl_low,
    input  wire logic other_sda_low,
    output logic      scl,
    output logic      sda
);
    // Pull-ups win unless a party sinks the line; nobody drives high
    // second master sinks lines
    assign scl = !((scl_oe && !scl_o) || other_scl_low);
    assign sda = !((sda_oe && !sda_o) || other_sda_low);
endmodule

// file: bench/i2cms_start_monitor.sv
// Port checker for the I2C start generator
`timescale 1ns/10ps
module i2cms_start_monitor
    import i2cms_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        SRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SCL_I,
    input wire logic        SCL_OE,
    input wire logic        SDA_I,
    input wire logic        SDA_O,
    input wire logic        SDA_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    logic acc;
    logic rel;
    assign acc = PSEL && PENABLE;
    assign rel = acc && PWRITE && PADDR == I2CMS_OFS_CTRL2
                 && PWDATA[I2CMS_CTRL_RELEASE_BIT];
    ////////////////////////////////////////////////////////////////////////
    property p_scl_free;
        !SCL_OE;
    endproperty
    a_scl_free: assert property (p_scl_free)
        else $error("SCL driven");
    property p_low_only;
        SDA_OE |-> !SDA_O;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("SDA driven high");
    property p_sda_cause;
        $rose(SDA_OE) |-> $past(SDA_I) && $past(SCL_I);
    endproperty
    a_sda_cause: assert property (p_sda_cause)
        else $error("SDA pulled with a line low");
    // Only a release write may free SDA once it is held
    property p_sda_held;
        $fell(SDA_OE) |-> $past(rel) || $past(rel, 2);
    endproperty
    a_sda_held: assert property (p_sda_held)
        else $error("SDA freed without release");
    property p_scl_block;
        !SCL_I [*5] |-> !$rose(SDA_OE);
    endproperty
    a_scl_block: assert property (p_scl_block)
        else $error("start despite SCL low");
    property p_ready;
        acc |-> PREADY;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state seen");
    property p_err_unmapped;
        acc && PADDR > I2CMS_OFS_IRQ_MASK |-> PSLVERR;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("no error on unmapped");
    property p_err_mapped;
        acc && PADDR <= I2CMS_OFS_IRQ_MASK && PADDR[1:0] == 2'b00
            |-> !PSLVERR;
    endproperty
    a_err_mapped: assert property (p_err_mapped)
        else $error("error on mapped");
endmodule
////////////////////////////////////////////////////////////////////////////
bind i2cms_start i2cms_start_monitor i_i2cms_start_monitor (
    .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCL_I(SCL_I), .SCL_OE(SCL_OE), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE)
);

// file: bench/i2cms_start_tb.sv
// Self-checking bench for the I2C start generator
`timescale 1ns/10ps
module i2cms_start_tb;
    import i2cms_pkg::*;
    logic        CLOCK = 1'b0;
    logic        SRST = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, SCL_I, SCL_O, SCL_OE;
    logic        SDA_I, SDA_O, SDA_OE, IRQ;
    logic        hold_scl = 1'b0;
    logic        hold_sda = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 CLOCK = ~CLOCK;
    end
    i2cms_start i_i2cms_start (
        .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(SCL_I), .SCL_O(SCL_O),
        .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
        .IRQ(IRQ)
    );
    i2cms_bus_model i_i2cms_bus_model (
        .scl_oe(SCL_OE), .scl_o(SCL_O), .sda_oe(SDA_OE), .sda_o(SDA_O),
        .other_scl_low(hold_scl), .other_sda_low(hold_sda),
        .scl(SCL_I), .sda(SDA_I)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic stall(input string what);
        n_mismatch++;
        $display("wrong value %s expected answer seen timeout", what);
        final_report();
    endtask
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // Setup and access phase; request held until PREADY sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) stall("pready");
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    // Ends on a falling edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
        @(negedge CLOCK);
    endtask
    task automatic clr;
        apb(1'b1, I2CMS_OFS_IRQ_STAT, 32'h00000007);
        hold_scl <= 1'b0;
        hold_sda <= 1'b0;
        apb(1'b1, I2CMS_OFS_IRQ_MASK, 32'h00000000);
        cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int a = 0; a < 24; a += 4) begin
            rchk(a[7:0], 32'h00000000);
        end
        apb(1'b0, 8'h18, 32'h00000000);
        chk("unmapped err", 32'h00000001, {31'h0, err});
        chk("unmapped data", 32'h00000000, rd);
        apb(1'b1, I2CMS_OFS_BUFFER, 32'h000001a5);
        rchk(I2CMS_OFS_BUFFER, 32'h000000a5);
    endtask
    task automatic t_coll_low;
        apb(1'b1, I2CMS_OFS_IRQ_MASK, 32'h00000001);
        hold_scl <= 1'b1;
        hold_sda <= 1'b1;
        cyc(6);
        apb(1'b1, I2CMS_OFS_CTRL2, 32'h00000001);
        cyc(10);
        chk("irq", 32'h00000001, {31'h0, IRQ});
        chk("sda oe", 32'h00000000, {31'h0, SDA_OE});
        rchk(I2CMS_OFS_STATUS, 32'h00000000);
        rchk(I2CMS_OFS_IRQ_STAT, 32'h00000001);
        clr();
    endtask
    task automatic t_coll_scl;
        apb(1'b1, I2CMS_OFS_IRQ_MASK, 32'h00000001);
        apb(1'b1, I2CMS_OFS_BAUD, 32'h00000028);
        apb(1'b1, I2CMS_OFS_CTRL2, 32'h00000001);
        rchk(I2CMS_OFS_CTRL2, 32'h00000001);
        repeat (8) @(posedge CLOCK);
        hold_scl <= 1'b1;
        cyc(10);
        chk("sda oe", 32'h00000000, {31'h0, SDA_OE});
        chk("irq", 32'h00000001, {31'h0, IRQ});
        rchk(I2CMS_OFS_STATUS, 32'h00000000);
        rchk(I2CMS_OFS_IRQ_STAT, 32'h00000001);
        clr();
    endtask
    task automatic t_start(input logic [6:0] r);
        int n;
        n = 0;
        apb(1'b1, I2CMS_OFS_BAUD, 32'hffffff80 | {25'h0, r});
        rchk(I2CMS_OFS_BAUD, {25'h0, r});
        apb(1'b1, I2CMS_OFS_CTRL2, 32'h00000001);
        while (SDA_OE !== 1'b1 && n < 200) begin
            @(negedge CLOCK);
            n++;
        end
        if (n == 200) stall("sda oe");
        chk("sda delay", {25'h0, r} + 32'h00000003, 32'(n));
        chk("scl oe", 32'h00000000, {31'h0, SCL_OE});
        rchk(I2CMS_OFS_STATUS, 32'h00000009);
        apb(1'b1, I2CMS_OFS_BUFFER, 32'h0000005a);
        apb(1'b1, I2CMS_OFS_CTRL2, 32'h0000009e);
        rchk(I2CMS_OFS_STATUS, 32'h00000009);
        rchk(I2CMS_OFS_CTRL2, 32'h00000001);
        cyc(2 * r + 8);
        chk("sda oe", 32'h00000001, {31'h0, SDA_OE});
        rchk(I2CMS_OFS_CTRL2, 32'h00000000);
        rchk(I2CMS_OFS_STATUS, 32'h0000000a);
        rchk(I2CMS_OFS_BUFFER, 32'h000000a5);
        rchk(I2CMS_OFS_IRQ_STAT, 32'h00000006);
        chk("irq", 32'h00000000, {31'h0, IRQ});
        apb(1'b1, I2CMS_OFS_IRQ_MASK, 32'h00000004);
        cyc(2);
        chk("irq", 32'h00000001, {31'h0, IRQ});
        apb(1'b1, I2CMS_OFS_IRQ_STAT, 32'h00000004);
        rchk(I2CMS_OFS_IRQ_STAT, 32'h00000002);
        cyc(2);
        chk("irq", 32'h00000000, {31'h0, IRQ});
        apb(1'b1, I2CMS_OFS_CTRL2, 32'h00000080);
        cyc(2);
        chk("sda oe", 32'h00000000, {31'h0, SDA_OE});
        rchk(I2CMS_OFS_STATUS, 32'h00000000);
        clr();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge CLOCK);
        SRST <= 1'b0;
        repeat (6) @(posedge CLOCK);
        t_reset();
        t_coll_low();
        t_start(7'd16);
        t_coll_scl();
        t_start(7'd40);
        final_report();
    end
endmodule

// file: rtl/i2cms_brg.sv
// Reloadable baud period down counter
`timescale 1ns/10ps
module i2cms_brg (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          load,
    input  wire logic                          stop,
    input  wire logic [i2cms_pkg::I2CMS_BAUD_W-1:0] reload,
    output logic                               timeout
);
    import i2cms_pkg::*;

    logic [I2CMS_BAUD_W-1:0] count_reg;
    logic                    run_reg;

    // Period is reload plus one cycles; zero still gives one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= I2CMS_BAUD_RST;
        end else if (load) begin
            count_reg <= reload;
        end else if (run_reg && count_reg != '0) begin
            count_reg <= count_reg - 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || stop) begin
            run_reg <= 1'b0;
        end else if (load) begin
            run_reg <= 1'b1;
        end else if (timeout) begin
            run_reg <= 1'b0;
        end
    end

    // Must not look at load: the sequencer reloads on this very timeout
    assign timeout = run_reg && count_reg == '0;
endmodule

// file: rtl/i2cms_pkg.sv
// Constants shared by the I2C master start generator files
package i2cms_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] I2CMS_OFS_CTRL2    = 8'h00;
    localparam logic [7:0] I2CMS_OFS_BAUD     = 8'h04;
    localparam logic [7:0] I2CMS_OFS_STATUS   = 8'h08;
    localparam logic [7:0] I2CMS_OFS_BUFFER   = 8'h0c;
    localparam logic [7:0] I2CMS_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] I2CMS_OFS_IRQ_MASK = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int I2CMS_CTRL_GO_BIT      = 0;
    localparam int I2CMS_CTRL_LOW_W       = 5;
    localparam int I2CMS_CTRL_RELEASE_BIT = 7;
    localparam int I2CMS_BAUD_W           = 7;
    localparam int I2CMS_BUF_W            = 8;
    localparam int I2CMS_STAT_BUSY_BIT    = 0;
    localparam int I2CMS_STAT_HOLD_BIT    = 1;
    localparam int I2CMS_STAT_START_BIT   = 3;
    localparam int I2CMS_IRQ_BCOL_BIT     = 0;
    localparam int I2CMS_IRQ_WRCOLL_BIT   = 1;
    localparam int I2CMS_IRQ_DONE_BIT     = 2;
    localparam int I2CMS_IRQ_W            = 3;
    localparam int I2CMS_SYNC_DEPTH       = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [I2CMS_CTRL_LOW_W-1:0] I2CMS_CTRL_RST = 5'h00;
    localparam logic [I2CMS_BAUD_W-1:0]     I2CMS_BAUD_RST = 7'h00;
    localparam logic [I2CMS_BUF_W-1:0]      I2CMS_BUF_RST  = 8'h00;
    localparam logic [I2CMS_IRQ_W-1:0]      I2CMS_IRQ_RST  = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Start sequencer states
    typedef enum logic [3:0] {
        I2CMS_IDLE  = 4'b0001,
        I2CMS_SETUP = 4'b0010,
        I2CMS_HOLDT = 4'b0100,
        I2CMS_DONE  = 4'b1000
    } i2cms_state_t;

endpackage

// file: rtl/i2cms_start.sv
// I2C master start generator with APB registers
//
// Contract
// - Setting start_enable (control bit 0) begins a Start.
// - With both lines high at request, the baud counter loads and runs.
// - Lines still high at timeout: SDA driven low, start_seen_flag set.
// - Second baud period, then start_enable self-clears, SDA stays low.
// - Both lines low at begin, or SCL low before SDA falls: collision.
// - Buffer writes during a Start set write_collision_flag, are dropped.
// - Writes to control bits 4..0 are ignored until the Start completes.
`timescale 1ns/10ps
module i2cms_start (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic             IRQ
);
    import i2cms_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    i2cms_state_t state_reg;
    i2cms_state_t state_next;

    logic                         scl_level;
    logic                         sda_level;
    logic                         brg_load;
    logic                         brg_stop;
    logic                         brg_timeout;
    logic [I2CMS_CTRL_LOW_W-1:0]  ctrl_reg;
    logic [I2CMS_BAUD_W-1:0]      baud_reg;
    logic [I2CMS_BUF_W-1:0]       buffer_reg;
    logic [I2CMS_IRQ_W-1:0]       irq_stat_reg;
    logic [I2CMS_IRQ_W-1:0]       irq_stat_next;
    logic [I2CMS_IRQ_W-1:0]       irq_mask_reg;
    logic [I2CMS_IRQ_W-1:0]       irq_set;
    logic                         start_seen_reg;
    logic                         sda_low_reg;
    logic                         busy;
    logic                         wr_access;
    logic                         rd_setup;
    logic                         addr_ok;
    logic                         wr_ctrl;
    logic                         wr_buffer;
    logic                         wr_baud;
    logic                         wr_irq_stat;
    logic                         wr_irq_mask;
    logic                         collision;
    logic                         start_done;
    logic                         sda_fall;
    logic                         release_cmd;
    logic [31:0]                  rd_value;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    i2cms_sync u_scl_sync (
        .clk    (CLOCK),
        .srst   (SRST),
        .pin_in (SCL_I),
        .level  (scl_level)
    );

    i2cms_sync u_sda_sync (
        .clk    (CLOCK),
        .srst   (SRST),
        .pin_in (SDA_I),
        .level  (sda_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Baud rate generator
    i2cms_brg u_brg (
        .clk     (CLOCK),
        .srst    (SRST),
        .load    (brg_load),
        .stop    (brg_stop),
        .reload  (baud_reg),
        .timeout (brg_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode; no wait states
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign rd_setup  = PSEL && !PENABLE && !PWRITE;
    assign PREADY    = 1'b1;

    always_comb begin
        unique case (PADDR)
            I2CMS_OFS_CTRL2,
            I2CMS_OFS_BAUD,
            I2CMS_OFS_STATUS,
            I2CMS_OFS_BUFFER,
            I2CMS_OFS_IRQ_STAT,
            I2CMS_OFS_IRQ_MASK: addr_ok = 1'b1;
            default:            addr_ok = 1'b0;
        endcase
    end

    assign PSLVERR     = PSEL && PENABLE && !addr_ok;
    assign wr_ctrl     = wr_access && PADDR == I2CMS_OFS_CTRL2;
    assign wr_baud     = wr_access && PADDR == I2CMS_OFS_BAUD;
    assign wr_buffer   = wr_access && PADDR == I2CMS_OFS_BUFFER;
    assign wr_irq_stat = wr_access && PADDR == I2CMS_OFS_IRQ_STAT;
    assign wr_irq_mask = wr_access && PADDR == I2CMS_OFS_IRQ_MASK;

    // Release is a control write too, so it is refused while busy
    assign release_cmd = wr_ctrl && !busy
                         && PWDATA[I2CMS_CTRL_RELEASE_BIT];

    // Start in progress while start_enable is set
    assign busy = ctrl_reg[I2CMS_CTRL_GO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Start sequencer
    always_comb begin
        state_next = state_reg;
        brg_load   = 1'b0;
        brg_stop   = 1'b0;
        collision  = 1'b0;
        start_done = 1'b0;
        sda_fall   = 1'b0;
        unique case (state_reg)
            I2CMS_IDLE: begin
                if (busy) begin
                    if (!scl_level && !sda_level) begin
                        collision = 1'b1;
                    end else if (scl_level && sda_level) begin
                        brg_load   = 1'b1;
                        state_next = I2CMS_SETUP;
                    end
                    // Mixed levels: request stays pending
                end
            end
            I2CMS_SETUP: begin
                if (!scl_level) begin
                    collision = 1'b1;
                end else if (brg_timeout) begin
                    if (sda_level) begin
                        sda_fall   = 1'b1;
                        brg_load   = 1'b1;
                        state_next = I2CMS_HOLDT;
                    end else begin
                        // Another master pulled SDA first
                        collision = 1'b1;
                    end
                end
            end
            I2CMS_HOLDT: begin
                if (brg_timeout) begin
                    start_done = 1'b1;
                    brg_stop   = 1'b1;
                    state_next = I2CMS_DONE;
                end
            end
            I2CMS_DONE: begin
                // Later bus phases take over from here
                if (release_cmd) begin
                    state_next = I2CMS_IDLE;
                end
            end
        endcase
        if (collision) begin
            brg_stop   = 1'b1;
            state_next = I2CMS_IDLE;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_reg <= I2CMS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_reg <= I2CMS_CTRL_RST;
        end else if (collision) begin
            ctrl_reg[I2CMS_CTRL_GO_BIT] <= 1'b0;
        end else if (start_done) begin
            ctrl_reg[I2CMS_CTRL_GO_BIT] <= 1'b0;
        end else if (wr_ctrl && !busy) begin
            ctrl_reg <= PWDATA[I2CMS_CTRL_LOW_W-1:0];
        end
    end

    // Baud reload value
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            baud_reg <= I2CMS_BAUD_RST;
        end else if (wr_baud) begin
            baud_reg <= PWDATA[I2CMS_BAUD_W-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            buffer_reg <= I2CMS_BUF_RST;
        end else if (wr_buffer && !busy) begin
            buffer_reg <= PWDATA[I2CMS_BUF_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start seen flag and SDA drive
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            start_seen_reg <= 1'b0;
        end else if (sda_fall) begin
            start_seen_reg <= 1'b1;
        end else if (collision || release_cmd) begin
            start_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            sda_low_reg <= 1'b0;
        end else if (sda_fall) begin
            sda_low_reg <= 1'b1;
        end else if (collision
                     || (release_cmd && state_reg == I2CMS_DONE)) begin
            sda_low_reg <= 1'b0;
        end
    end

    // Open drain: only ever drive low
    // SDA held until release
    assign SDA_O  = 1'b0;
    assign SDA_OE = sda_low_reg;

    assign SCL_O  = 1'b0;
    assign SCL_OE = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupts; a set in the clearing cycle wins
    always_comb begin
        irq_set                     = '0;
        irq_set[I2CMS_IRQ_BCOL_BIT] = collision;
        irq_set[I2CMS_IRQ_WRCOLL_BIT] = wr_buffer && busy;
        irq_set[I2CMS_IRQ_DONE_BIT] = start_done;
        irq_stat_next = irq_stat_reg;
        if (wr_irq_stat) begin
            irq_stat_next = irq_stat_reg & ~PWDATA[I2CMS_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_set;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            irq_stat_reg <= I2CMS_IRQ_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt mask and output
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            irq_mask_reg <= I2CMS_IRQ_RST;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= PWDATA[I2CMS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_next & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, captured in the setup cycle
    always_comb begin
        rd_value = '0;
        unique case (PADDR)
            I2CMS_OFS_CTRL2: begin
                rd_value[I2CMS_CTRL_LOW_W-1:0] = ctrl_reg;
            end
            I2CMS_OFS_BAUD: begin
                rd_value[I2CMS_BAUD_W-1:0] = baud_reg;
            end
            I2CMS_OFS_STATUS: begin
                rd_value[I2CMS_STAT_BUSY_BIT]  = busy;
                rd_value[I2CMS_STAT_HOLD_BIT]  = state_reg == I2CMS_DONE;
                rd_value[I2CMS_STAT_START_BIT] = start_seen_reg;
            end
            I2CMS_OFS_BUFFER: begin
                rd_value[I2CMS_BUF_W-1:0] = buffer_reg;
            end
            I2CMS_OFS_IRQ_STAT: begin
                rd_value[I2CMS_IRQ_W-1:0] = irq_stat_reg;
            end
            I2CMS_OFS_IRQ_MASK: begin
                rd_value[I2CMS_IRQ_W-1:0] = irq_mask_reg;
            end
            default: begin
                rd_value = '0;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            PRDATA <= '0;
        end else if (rd_setup) begin
            PRDATA <= rd_value;
        end
    end
endmodule

// file: rtl/i2cms_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module i2cms_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level
);
    import i2cms_pkg::*;

    logic [I2CMS_SYNC_DEPTH-1:0] stage_reg;

    // Idle bus is high, so reset to high
    always_ff @(posedge clk) begin
        if (srst) begin
            stage_reg <= '1;
        end else begin
            stage_reg <= {stage_reg[I2CMS_SYNC_DEPTH-2:0], pin_in};
        end
    end

    // Stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (srst) begin
            level <= 1'b1;
        end else if (stage_reg[1] == stage_reg[2]) begin
            level <= stage_reg[2];
        end
    end
endmodule
